// ==== core/switch_misc_pkg.sv ====
package switch_misc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0]  OFF_PHY_MARGIN   = 8'h94;  // Transmit margin and equalisation
  localparam logic [7:0]  OFF_MODE_CLKBUF  = 8'h98;  // Strap view and refclk control
  localparam logic [7:0]  OFF_SUBSYS_CAP   = 8'hb0;  // Subsystem capability header
  localparam logic [7:0]  OFF_SUBSYS_ID    = 8'hb4;  // Vendor and device codes
  localparam logic [7:0]  OFF_GPIO_CTRL    = 8'hb8;  // Pin control, upstream only

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          RXEQ_LSB         = 16;     // Equalisation field low bit
  localparam int          CLKBUF_EN_LSB    = 16;     // Per-pair enables low bit
  localparam int          REFCLK_OFF_BIT   = 20;     // Global power-down bit
  localparam int          NEXT_PTR_LSB     = 8;      // Next capability pointer low bit
  localparam int          DEVICE_CODE_LSB  = 16;     // Device code low bit
  localparam int          GPIO_IN_POS      = 0;      // Input state within a nibble
  localparam int          GPIO_DIR_POS     = 1;      // Direction within a nibble
  localparam int          GPIO_VAL_POS     = 2;      // Output value within a nibble
  localparam int          GPIO_STRIDE      = 4;      // Bits per pin

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and constants
  localparam logic [15:0] TX_MARGIN_RST    = 16'h116b; // Transmit margin default
  localparam logic [7:0]  RXEQ_UP_RST      = 8'h86;    // Equalisation, upstream
  localparam logic [7:0]  RXEQ_DN_RST      = 8'h00;    // Reserved on downstream
  localparam logic [3:0]  CLKBUF_EN_RST    = 4'hf;     // All pairs enabled
  localparam logic        REFCLK_OFF_RST   = 1'b0;     // Held until strap is taken
  localparam logic [7:0]  SUBSYS_CAP_ID    = 8'h0d;    // Capability identifier
  localparam logic [7:0]  NEXT_PTR_RST     = 8'hc0;    // Link to next structure
  localparam logic [6:0]  MODE_PAD         = 7'h00;    // Zero bits above straps

  //////////////////////////////////////////////////////////////////////////////
  // Timing counts
  localparam logic [1:0]  STRAP_SETTLE     = 2'h2;     // Cycles for strap synchroniser

  //////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       scanTest;              // Scan test strap
    logic [2:0] packageSelect;         // Package select strap
    logic       serdesConfig;          // Serdes configuration strap
    logic       diagnostic;            // Diagnostic strap
    logic       accelerated;           // Accelerated strap
    logic       quiescentCurrentTestN; // Quiescent test strap, active low
    logic       eepromLoadSkip;        // Eeprom skip strap
  } strap_t;

  typedef struct packed {
    logic       powerDown;             // Disable all reference clocks
    logic [3:0] pairEnable;            // Per-pair enables
  } clkbuf_t;

  typedef struct packed {
    logic        valid;                // One-cycle request
    logic [7:0]  addr;                 // Byte offset
    logic [31:0] data;                 // Write data
  } load_t;

endpackage

// ==== core/bit_sync.sv ====
`timescale 1ns/10ps
module bit_sync
  import switch_misc_pkg::*;
#(
  parameter int WIDTH = 1                 // Number of bits
) (
  input  wire logic             clk,      // Core clock
  input  wire logic             sys_rst,  // Async reset, active high
  input  wire logic [WIDTH-1:0] din,      // Asynchronous levels
  output logic      [WIDTH-1:0] dout      // Synchronised levels
);

  logic [WIDTH-1:0] stage1_reg;           // First stage, read only by second
  logic [WIDTH-1:0] stage2_reg;           // Second stage
  logic [WIDTH-1:0] stage1_next;          // Next first stage
  logic [WIDTH-1:0] stage2_next;          // Next second stage

  // Shift the levels along the chain
  always_comb begin
    stage1_next = din;
    stage2_next = stage1_reg;
  end

  // Two flops; metastability settles between them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign dout = stage2_reg;

endmodule

// ==== core/refclk_gate.sv ====
`timescale 1ns/10ps
module refclk_gate
  import switch_misc_pkg::*;
(
  input  wire logic       clk,            // Core clock
  input  wire logic       sys_rst,        // Async reset, active high
  input  wire clkbuf_t    ctrl,           // Buffer control field
  output logic      [3:0] pairEnable      // Registered buffer enables
);

  logic [3:0] enable_reg;                 // Registered enables
  logic [3:0] enable_next;                // Next enables

  // Global power-down overrides every pair
  always_comb begin
    // (RQ4) global disable
    // (RQ5) per-pair gate
    enable_next = ctrl.powerDown ? 4'h0 : ctrl.pairEnable;
  end

  // Buffers stay off in reset; with the power-down strap high they still run for three cycles after it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= 4'h0;
    end else begin
      enable_reg <= enable_next;
    end
  end

  assign pairEnable = enable_reg;

endmodule

// ==== core/switch_misc_config_gpio_regs.sv ====
// Function
// (RQ1) Margin 116Bh, equalisation 86h upstream only
// (RQ2) Mode word: zeros then strap levels
// (RQ3) Power-down bit taken from strap pin
// (RQ4) Power-down bit set disables all clocks
// (RQ5) Bits 19-16 gate pairs, reset Fh
// (RQ6) Buffer control overridable by strap, load
// (RQ7) Capability header low byte reads 0Dh
// (RQ8) Next pointer read-only, reset C0h
// (RQ9) Vendor code low half, load overridable
// (RQ10) Device code high half, load overridable
// (RQ11) Pin control exists on upstream only
// (RQ12) Input bits show sampled pin levels
// (RQ13) Direction bits: 1 output, reset 0
// (RQ14) Value bits driven when output selected
// (RQ15) Reserved bits read zero, ignore writes
// (RQ16) Pin inputs pass two-flop synchroniser
`timescale 1ns/10ps
module switch_misc_config_gpio_regs
  import switch_misc_pkg::*;
#(
  parameter bit          IS_UPSTREAM     = 1'b1,     // Port is the upstream port
  parameter int          GPIO_PINS       = 4,        // General purpose pins
  parameter logic [15:0] VENDOR_CODE_RST = 16'h5a5a, // Arbitrary neutral value
  parameter logic [15:0] DEVICE_CODE_RST = 16'ha5c3  // Arbitrary neutral value
) (
  input  wire logic                 clk,             // Core clock
  input  wire logic                 sys_rst,         // Port reset, active high
  input  wire logic [7:0]           cfgAddr,         // Config byte offset
  input  wire logic                 cfgRdEn,         // Config read strobe
  input  wire logic                 cfgWrEn,         // Config write strobe
  input  wire logic [3:0]           cfgByteEn,       // Config write byte enables
  input  wire logic [31:0]          cfgWrData,       // Config write data
  output logic      [31:0]          cfgRdData,       // Config read data
  output logic                      cfgRdValid,      // Read data valid pulse
  input  wire load_t                defaultLoad,     // Default override from SMBus or EEPROM
  input  wire strap_t               strapPins,       // Mode strap pins
  input  wire logic                 refclkBufferPowerdownStrap, // Power-down strap pin
  output logic      [3:0]           refclkOutPairEnable,        // Refclk buffer enables
  input  wire logic [GPIO_PINS-1:0] gpioIn,          // Pin levels
  output logic      [GPIO_PINS-1:0] gpioOut,         // Pin drive values
  output logic      [GPIO_PINS-1:0] gpioOe           // Pin output enables
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Word decode shared by read, write and load paths
  function automatic logic wordHit(input logic [7:0] addr, input logic [7:0] off);
    wordHit = (addr[7:2] == off[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [15:0]          txMargin_reg;        // Transmit margin
  logic [15:0]          txMargin_next;       // Next transmit margin
  logic [7:0]           rxEq_reg;            // Multilane equalisation
  logic [7:0]           rxEq_next;           // Next equalisation
  clkbuf_t              clkbuf_reg;          // Buffer control field
  clkbuf_t              clkbuf_next;         // Next buffer control
  logic [15:0]          vendor_reg;          // Subsystem vendor code
  logic [15:0]          vendor_next;         // Next vendor code
  logic [15:0]          device_reg;          // Subsystem device code
  logic [15:0]          device_next;         // Next device code
  logic [GPIO_PINS-1:0] gpioDir_reg;         // Direction, 1 is output
  logic [GPIO_PINS-1:0] gpioDir_next;        // Next direction
  logic [GPIO_PINS-1:0] gpioVal_reg;         // Output values
  logic [GPIO_PINS-1:0] gpioVal_next;        // Next output values
  logic [1:0]           settle_reg;          // Strap settle counter
  logic [1:0]           settle_next;         // Next settle count
  logic                 strapTaken_reg;      // Strap already captured
  logic                 strapTaken_next;     // Next capture flag
  logic [31:0]          rdData_reg;          // Read data
  logic [31:0]          rdData_next;         // Next read data
  logic                 rdValid_reg;         // Read data valid
  logic                 rdValid_next;        // Next read valid
  strap_t               strapSync;           // Synchronised straps
  logic                 pdStrapSync;         // Synchronised power-down strap
  logic [GPIO_PINS-1:0] gpioSync;            // Synchronised pin levels
  logic [15:0]          gpioWord;            // Assembled pin control word
  logic                 loadPhy;             // Load hits margin register
  logic                 loadClk;             // Load hits buffer control
  logic                 loadSub;             // Load hits subsystem codes
  logic                 cfgGpioWr;           // Config write to pin control
  logic [7:0]           rxEqReset;           // Port-dependent reset value

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  // (RQ16) strap and pin synchronisers
  bit_sync #(
    .WIDTH ($bits(strap_t) + 1)
  ) u_strap_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({strapPins, refclkBufferPowerdownStrap}),
    .dout    ({strapSync, pdStrapSync})
  );

  // (RQ16) pin input synchroniser
  bit_sync #(
    .WIDTH (GPIO_PINS)
  ) u_gpio_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (gpioIn),
    .dout    (gpioSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Downstream ports carry a reserved, zero equalisation field
  assign rxEqReset = IS_UPSTREAM ? RXEQ_UP_RST : RXEQ_DN_RST;

  // Default loads address whole words; fields are picked out below
  always_comb begin
    loadPhy   = defaultLoad.valid && wordHit(defaultLoad.addr, OFF_PHY_MARGIN);
    loadClk   = defaultLoad.valid && wordHit(defaultLoad.addr, OFF_MODE_CLKBUF);
    loadSub   = defaultLoad.valid && wordHit(defaultLoad.addr, OFF_SUBSYS_ID);
    // (RQ11) upstream-only write decode
    cfgGpioWr = cfgWrEn && IS_UPSTREAM && wordHit(cfgAddr, OFF_GPIO_CTRL);
  end

  // Pin control word; reserved nibble bits stay zero
  always_comb begin
    gpioWord = 16'h0000;
    for (int i = 0; i < GPIO_PINS; i++) begin
      // (RQ12) input state bits
      gpioWord[i*GPIO_STRIDE + GPIO_IN_POS]  = gpioSync[i];
      gpioWord[i*GPIO_STRIDE + GPIO_DIR_POS] = gpioDir_reg[i];
      gpioWord[i*GPIO_STRIDE + GPIO_VAL_POS] = gpioVal_reg[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override registers

  // Read-only fields that only the default load may change
  always_comb begin
    txMargin_next = txMargin_reg;
    rxEq_next     = rxEq_reg;
    vendor_next   = vendor_reg;
    device_next   = device_reg;
    if (loadPhy) begin
      // (RQ1) margin and equalisation load
      txMargin_next = defaultLoad.data[15:0];
      // Reserved on downstream, so the load cannot reach it there
      rxEq_next     = IS_UPSTREAM ? defaultLoad.data[RXEQ_LSB +: 8] : RXEQ_DN_RST;
    end
    if (loadSub) begin
      // (RQ9) vendor code load
      vendor_next = defaultLoad.data[15:0];
      // (RQ10) device code load
      device_next = defaultLoad.data[DEVICE_CODE_LSB +: 16];
    end
  end

  // Field storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txMargin_reg <= TX_MARGIN_RST;
      rxEq_reg     <= IS_UPSTREAM ? RXEQ_UP_RST : RXEQ_DN_RST;
      vendor_reg   <= VENDOR_CODE_RST;
      device_reg   <= DEVICE_CODE_RST;
    end else begin
      txMargin_reg <= txMargin_next;
      rxEq_reg     <= rxEq_next;
      vendor_reg   <= vendor_next;
      device_reg   <= device_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock buffer control

  // The strap is caught once, after its synchroniser has settled;
  // a flop under async reset may not take a pin value directly
  always_comb begin
    settle_next     = settle_reg;
    strapTaken_next = strapTaken_reg;
    clkbuf_next     = clkbuf_reg;
    if (!strapTaken_reg) begin
      if (settle_reg == STRAP_SETTLE) begin
        // (RQ3) strap sets power-down
        clkbuf_next.powerDown = pdStrapSync;
        strapTaken_next       = 1'b1;
      end else begin
        settle_next = settle_reg + 2'h1;
      end
    end
    // A load in the capture cycle wins; it is the later source
    if (loadClk) begin
      // (RQ6) load overrides default
      clkbuf_next.powerDown  = defaultLoad.data[REFCLK_OFF_BIT];
      clkbuf_next.pairEnable = defaultLoad.data[CLKBUF_EN_LSB +: 4];
    end
  end

  // Control state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_reg      <= 2'h0;
      strapTaken_reg  <= 1'b0;
      // (RQ5) pairs reset enabled
      clkbuf_reg      <= '{powerDown: REFCLK_OFF_RST, pairEnable: CLKBUF_EN_RST};
    end else begin
      settle_reg      <= settle_next;
      strapTaken_reg  <= strapTaken_next;
      clkbuf_reg      <= clkbuf_next;
    end
  end

  // Output buffer gating
  refclk_gate u_refclk_gate (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ctrl       (clkbuf_reg),
    .pairEnable (refclkOutPairEnable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // General purpose pin control

  // Only direction and value bits take writes, from byte lanes 0 and 1
  always_comb begin
    gpioDir_next = gpioDir_reg;
    gpioVal_next = gpioVal_reg;
    if (cfgGpioWr) begin
      for (int i = 0; i < GPIO_PINS; i++) begin
        if (cfgByteEn[(i*GPIO_STRIDE)/8]) begin
          // (RQ13) direction write
          gpioDir_next[i] = cfgWrData[i*GPIO_STRIDE + GPIO_DIR_POS];
          // (RQ14) value write
          gpioVal_next[i] = cfgWrData[i*GPIO_STRIDE + GPIO_VAL_POS];
        end
      end
    end
  end

  // Pin control storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // (RQ13) inputs after reset
      gpioDir_reg <= '0;
      gpioVal_reg <= '0;
    end else begin
      gpioDir_reg <= gpioDir_next;
      gpioVal_reg <= gpioVal_next;
    end
  end

  // Pins are never driven on a downstream port
  always_comb begin
    // (RQ14) drive when output
    gpioOut = gpioVal_reg;
    // (RQ11) no pins downstream
    gpioOe  = IS_UPSTREAM ? gpioDir_reg : '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // One-cycle read latency; unmapped offsets return zero
  always_comb begin
    rdValid_next = cfgRdEn;
    rdData_next  = rdData_reg;
    if (cfgRdEn) begin
      // (RQ15) reserved reads zero
      rdData_next = 32'h0000_0000;
      if (wordHit(cfgAddr, OFF_PHY_MARGIN)) begin
        // (RQ1) margin and equalisation
        rdData_next[15:0]            = txMargin_reg;
        rdData_next[RXEQ_LSB +: 8]   = IS_UPSTREAM ? rxEq_reg : rxEqReset;
      end else if (wordHit(cfgAddr, OFF_MODE_CLKBUF)) begin
        // (RQ2) strap mode view
        rdData_next[15:0]            = {MODE_PAD, strapSync};
        rdData_next[REFCLK_OFF_BIT]  = clkbuf_reg.powerDown;
        rdData_next[CLKBUF_EN_LSB +: 4] = clkbuf_reg.pairEnable;
      end else if (wordHit(cfgAddr, OFF_SUBSYS_CAP)) begin
        // (RQ7) capability identifier
        rdData_next[7:0]             = SUBSYS_CAP_ID;
        // (RQ8) next pointer
        rdData_next[NEXT_PTR_LSB +: 8] = NEXT_PTR_RST;
      end else if (wordHit(cfgAddr, OFF_SUBSYS_ID)) begin
        // (RQ9) vendor code
        rdData_next[15:0]            = vendor_reg;
        // (RQ10) device code
        rdData_next[DEVICE_CODE_LSB +: 16] = device_reg;
      end else if (IS_UPSTREAM && wordHit(cfgAddr, OFF_GPIO_CTRL)) begin
        // (RQ11) upstream pin control
        rdData_next[15:0]            = gpioWord;
      end
    end
  end

  // Read registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_reg  <= 32'h0000_0000;
      rdValid_reg <= 1'b0;
    end else begin
      rdData_reg  <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  assign cfgRdData  = rdData_reg;
  assign cfgRdValid = rdValid_reg;

endmodule

// ==== verification/switch_misc_chk.sv ====
`timescale 1ns/10ps
module switch_misc_chk
  import switch_misc_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1, // Port is the upstream port
  parameter int GPIO_PINS   = 4     // General purpose pins
) (
  input wire logic                 clk,        // Core clock
  input wire logic                 sys_rst,    // Async reset
  input wire logic [7:0]           cfgAddr,    // Config offset
  input wire logic                 cfgRdEn,    // Read strobe
  input wire logic                 cfgWrEn,    // Write strobe
  input wire logic [3:0]           cfgByteEn,  // Byte enables
  input wire logic [31:0]          cfgWrData,  // Write data
  input wire logic [31:0]          cfgRdData,  // Read data
  input wire logic                 cfgRdValid, // Read valid
  input wire logic [GPIO_PINS-1:0] gpioIn,     // Pin levels
  input wire logic [GPIO_PINS-1:0] gpioOut,    // Pin drive values
  input wire logic [GPIO_PINS-1:0] gpioOe      // Pin drive enables
);
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  rd_valid_a: assert property (cfgRdEn |=> cfgRdValid) else $error("read valid missing");
  rd_pulse_a: assert property (!cfgRdEn |=> !cfgRdValid) else $error("read valid without request");
  cap_hdr_a: assert property (cfgRdEn && cfgAddr == OFF_SUBSYS_CAP |=>
    cfgRdData == {16'h0000, NEXT_PTR_RST, SUBSYS_CAP_ID}) else $error("capability header wrong");
  unmapped_rd_a: assert property (cfgRdEn && cfgAddr == 8'h00 |=> cfgRdData == 32'h0)
    else $error("unmapped read not zero");
  mode_rsvd_a: assert property (cfgRdEn && cfgAddr == OFF_MODE_CLKBUF |=>
    cfgRdData[31:21] == 11'h000 && cfgRdData[15:9] == MODE_PAD) else $error("mode reserved bits set");
  pin_rsvd_a: assert property (cfgRdEn && cfgAddr == OFF_GPIO_CTRL |=>
    cfgRdData[31:15] == 17'h0 && !cfgRdData[11] && !cfgRdData[7] && !cfgRdData[3])
    else $error("pin control reserved bits set");
  pin_dir_a: assert property (IS_UPSTREAM && cfgWrEn && cfgAddr == OFF_GPIO_CTRL && cfgByteEn[0] |=>
    gpioOe[1:0] == {$past(cfgWrData[5]), $past(cfgWrData[1])}) else $error("direction not taken");
  pin_val_a: assert property (IS_UPSTREAM && cfgWrEn && cfgAddr == OFF_GPIO_CTRL && cfgByteEn[0] |=>
    !gpioOe[0] || gpioOut[0] == $past(cfgWrData[2])) else $error("drive value not taken");
  pin_hold_a: assert property (!(cfgWrEn && cfgAddr == OFF_GPIO_CTRL) |=> $stable(gpioOe))
    else $error("direction changed without write");
  down_pin_a: assert property (!IS_UPSTREAM |-> gpioOe == '0) else $error("downstream drives pins");
  // Pins held steady long enough to cross the synchroniser
  pin_sync_a: assert property (IS_UPSTREAM && $stable(gpioIn)[*4] ##0
    (cfgRdEn && cfgAddr == OFF_GPIO_CTRL) |=> cfgRdData[0] == $past(gpioIn[0]))
    else $error("input bit not pin level");
endmodule
bind switch_misc_config_gpio_regs switch_misc_chk #(.IS_UPSTREAM(IS_UPSTREAM), .GPIO_PINS(GPIO_PINS))
  switch_misc_chk_i (.clk(clk), .sys_rst(sys_rst), .cfgAddr(cfgAddr), .cfgRdEn(cfgRdEn),
  .cfgWrEn(cfgWrEn), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
  .cfgRdValid(cfgRdValid), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe));

// ==== verification/pin_partner.sv ====
`timescale 1ns/10ps
module pin_partner (
  input  wire logic       clk,       // Source for buffered clocks
  input  wire logic [3:0] gpioOut,   // Design drive values
  input  wire logic [3:0] gpioOe,    // Design drive enables
  input  wire logic [3:0] extLevel,  // Board drive on input pins
  input  wire logic [3:0] refclkEn,  // Buffer enables
  output logic      [3:0] gpioIn,    // Resolved pin levels
  output logic      [3:0] refclkOut  // Buffered clocks, still when off
);
  // The board source is always driven, so no floating pin is modelled
  // enabled drive wins
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gpioIn[i] = gpioOe[i] ? gpioOut[i] : extLevel[i];
    end
  end
  assign refclkOut = refclkEn & {4{clk}};
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import switch_misc_pkg::*;
;
  localparam logic [15:0] VND = 16'h3c3c; // Arbitrary value
  localparam logic [15:0] DEV = 16'hc3a1; // Arbitrary value
  logic clk, sys_rst, cfgRdEn, cfgWrEn, pdStrap;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn, extLevel;
  logic [31:0] cfgWrData, upData, dnData;
  load_t defaultLoad;
  strap_t strapPins;
  wire logic [31:0] upRd, dnRd;
  wire logic upValid, dnValid;
  wire logic [3:0] upRef, dnRef, upOut, upOe, dnOut, dnOe, pinLevel, refOut;
  int miscompares, checksDone;
  ////////////////////////////////////////
  switch_misc_config_gpio_regs #(.IS_UPSTREAM(1'b1), .VENDOR_CODE_RST(VND), .DEVICE_CODE_RST(DEV))
    switch_misc_config_gpio_regs_i (.clk(clk), .sys_rst(sys_rst), .cfgAddr(cfgAddr), .cfgRdEn(cfgRdEn),
    .cfgWrEn(cfgWrEn), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(upRd), .cfgRdValid(upValid),
    .defaultLoad(defaultLoad), .strapPins(strapPins), .refclkBufferPowerdownStrap(pdStrap),
    .refclkOutPairEnable(upRef), .gpioIn(pinLevel), .gpioOut(upOut), .gpioOe(upOe));
  // Downstream copy shares the bus to show what it lacks
  switch_misc_config_gpio_regs #(.IS_UPSTREAM(1'b0), .VENDOR_CODE_RST(VND), .DEVICE_CODE_RST(DEV))
    dn_i (.clk(clk), .sys_rst(sys_rst), .cfgAddr(cfgAddr), .cfgRdEn(cfgRdEn),
    .cfgWrEn(cfgWrEn), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(dnRd), .cfgRdValid(dnValid),
    .defaultLoad(defaultLoad), .strapPins(strapPins), .refclkBufferPowerdownStrap(pdStrap),
    .refclkOutPairEnable(dnRef), .gpioIn(extLevel), .gpioOut(dnOut), .gpioOe(dnOe));
  pin_partner pin_partner_i (.clk(clk), .gpioOut(upOut), .gpioOe(upOe), .extLevel(extLevel),
    .refclkEn(upRef), .gpioIn(pinLevel), .refclkOut(refOut));
  ////////////////////////////////////////
  always #5 clk = ~clk;
  // Compare tasks, one per result width
  task chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task chk4(input string name, input logic [3:0] exp, input logic [3:0] got);
    chk32(name, {28'h0, exp}, {28'h0, got});
  endtask
  // Read: strobe for one edge, data is valid one cycle later
  task rd(input logic [7:0] a);
    @(posedge clk);
    cfgAddr <= a;
    cfgRdEn <= 1'b1;
    @(posedge clk);
    cfgRdEn <= 1'b0;
    #1;
    chk4("read valid", 4'h3, {2'h0, dnValid, upValid});
    upData = upRd;
    dnData = dnRd;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] exp, input string name);
    rd(a);
    chk32(name, exp, upData);
  endtask
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfgAddr <= a;
    cfgByteEn <= be;
    cfgWrData <= d;
    cfgWrEn <= 1'b1;
    @(posedge clk);
    cfgWrEn <= 1'b0;
    #1;
  endtask
  // Default override; buffer outputs follow two cycles later
  task ld(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    defaultLoad <= '{1'b1, a, d};
    @(posedge clk);
    defaultLoad.valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task finish_test;
    $display("miscompares %0d checksDone %0d", miscompares, checksDone);
    if (miscompares == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 0; sys_rst = 1; cfgRdEn = 0; cfgWrEn = 0; cfgAddr = 0; cfgByteEn = 0; cfgWrData = 0;
    defaultLoad = '0; strapPins = strap_t'(9'h1a5); pdStrap = 0; extLevel = 4'ha;
    miscompares = 0; checksDone = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    repeat (6) @(posedge clk);
    rc(OFF_SUBSYS_CAP, {16'h0, NEXT_PTR_RST, SUBSYS_CAP_ID}, "cap header");
    rc(OFF_PHY_MARGIN, {8'h0, RXEQ_UP_RST, TX_MARGIN_RST}, "phy up");
    chk32("phy dn", {8'h0, RXEQ_DN_RST, TX_MARGIN_RST}, dnData);
    rc(OFF_MODE_CLKBUF, {11'h0, 1'b0, CLKBUF_EN_RST, MODE_PAD, 9'h1a5}, "mode");
    chk4("refclk", 4'hf, upRef);
    chk4("dn refclk", 4'hf, dnRef);
    rc(OFF_SUBSYS_ID, {DEV, VND}, "ids");
    rc(OFF_GPIO_CTRL, 32'h0000_1010, "pins reset");
    rc(8'h00, 32'h0, "unmapped 00");
    rc(8'hbc, 32'h0, "unmapped bc");
    // Overrides from the load port
    ld(OFF_MODE_CLKBUF, 32'h0005_0000);
    chk4("refclk pairs", 4'h5, upRef);
    chk4("refclk out", 4'h5, refOut);
    ld(OFF_MODE_CLKBUF, 32'h001f_0000);
    chk4("refclk off", 4'h0, upRef);
    rc(OFF_MODE_CLKBUF, 32'h001f_01a5, "mode loaded");
    ld(OFF_SUBSYS_ID, 32'h1234_5678);
    rc(OFF_SUBSYS_ID, 32'h1234_5678, "ids loaded");
    ld(OFF_PHY_MARGIN, 32'hff33_4444);
    rc(OFF_PHY_MARGIN, 32'h0033_4444, "phy loaded");
    chk32("phy dn loaded", 32'h0000_4444, dnData);
    wr(OFF_PHY_MARGIN, 4'hf, 32'h0);
    rc(OFF_PHY_MARGIN, 32'h0033_4444, "phy write ignored");
    // Pin control: all out high, then upper byte back to input
    wr(OFF_GPIO_CTRL, 4'hf, 32'hffff_ffff);
    chk4("oe all", 4'hf, upOe);
    chk4("out all", 4'hf, upOut);
    chk4("dn oe", 4'h0, dnOe);
    chk4("dn out", 4'h0, dnOut);
    repeat (4) @(posedge clk);
    rc(OFF_GPIO_CTRL, 32'h0000_7777, "pins driven");
    chk32("dn pins", 32'h0, dnData);
    wr(OFF_GPIO_CTRL, 4'h2, 32'h0);
    chk4("oe low", 4'h3, upOe);
    chk4("out low", 4'h3, upOut);
    extLevel <= 4'h5;
    repeat (4) @(posedge clk);
    rc(OFF_GPIO_CTRL, 32'h0000_0177, "pins mixed");
    // Value set while direction is input must not drive
    wr(OFF_GPIO_CTRL, 4'h1, 32'h0000_0004);
    chk4("oe input", 4'h0, upOe);
    repeat (4) @(posedge clk);
    rc(OFF_GPIO_CTRL, 32'h0000_0105, "pins input");
    // Second reset with the power-down strap high
    @(posedge clk);
    pdStrap <= 1;
    sys_rst <= 1;
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    repeat (6) @(posedge clk);
    chk4("refclk strap", 4'h0, upRef);
    rc(OFF_MODE_CLKBUF, {11'h0, 1'b1, CLKBUF_EN_RST, MODE_PAD, 9'h1a5}, "mode strap");
    chk4("oe reset", 4'h0, upOe);
    rc(OFF_GPIO_CTRL, 32'h0000_0101, "pins reset again");
    finish_test;
  end
  // Watchdog well past the hundred or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    finish_test;
  end
endmodule
